/* File: rtl/ufir_core.sv */
// UART channel core: flow control, interrupts, FIFOs, infrared and multidrop.
// Assumes a sample tick divisor from outside and control bits as plain ports.
`timescale 1ns/1ps
`include "ufir_regs.svh"
module ufir_core #(
    parameter bit FIFO_EN = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [`UFIR_DIV_W-1:0] sample_div_i,
    input wire logic [5:0] fifo_control_reg_i,
    input wire logic [4:0] line_control_reg_i,
    input wire logic line_control_write_i,
    input wire logic infrared_mode_enable_i,
    input wire logic [3:0] multidrop_control_reg_i,
    input wire logic tx_write_i,
    input wire logic [7:0] transmit_holding_reg_i,
    output logic tx_full_o,
    input wire logic rx_read_i,
    output logic [7:0] receive_buffer_reg_o,
    output logic rx_empty_o,
    output logic [3:0] line_status_o,
    input wire logic [`UFIR_IRQ_W-1:0] irq_enable_set_reg_i,
    input wire logic [`UFIR_IRQ_W-1:0] irq_enable_clear_reg_i,
    input wire logic [`UFIR_IRQ_W-1:0] masked_status_clear_reg_i,
    output logic [`UFIR_IRQ_W-1:0] irq_mask_view_reg_o,
    output logic [`UFIR_IRQ_W-1:0] raw_irq_status_reg_o,
    output logic [`UFIR_IRQ_W-1:0] masked_status_reg_o,
    output logic irq_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic request_send_out_n_o,
    input wire logic clear_send_in_n_i,
    output logic clear_send_out_n_o,
    output logic clear_send_oe_n_o,
    input wire logic data_set_ready_n_i,
    input wire logic ring_ind_n_i,
    input wire logic carrier_det_n_i
);
    localparam int DEPTH = FIFO_EN ? `UFIR_FIFO_DEPTH : 1;

    typedef struct packed {
        logic [`UFIR_DIV_W-1:0] div_cnt;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [3:0] modem_prev;
        ufir_pkg::ufir_tx_t tx_st;
        logic [`UFIR_SMP_W-1:0] tx_smp;
        logic [3:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic tx_hold;
        ufir_pkg::ufir_rx_t rx_st;
        logic [`UFIR_SMP_W-1:0] rx_smp;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic ir_seen;
        logic rts_flag;
        logic dir_level;
        logic [`UFIR_IRQ_W-1:0] mask;
        logic [`UFIR_IRQ_W-1:0] sticky;
        logic [3:0] line_flags;
        logic [`UFIR_TO_W-1:0] to_cnt;
        logic serial_out;
        logic rts_out;
        logic cts_out;
    } ufir_st_t;

    localparam ufir_st_t ST_RST = '{
        tx_st: ufir_pkg::TX_IDLE,
        rx_st: ufir_pkg::RX_IDLE,
        sync1: `UFIR_SY_RST,
        sync2: `UFIR_SY_RST,
        modem_prev: `UFIR_MODEM_RST, // Matches synchroniser reset: no false change
        mask: `UFIR_MASK_RST,
        dir_level: 1'b1,
        serial_out: 1'b1,
        cts_out: 1'b1,
        default: '0
    };

    ufir_st_t s;
    ufir_st_t next_s;

    logic tick;
    logic ir;
    logic md_en;
    logic dir_en;
    logic dir_sel;
    logic acts;
    logic cts_stop;
    logic [3:0] db;
    logic tx_pen;
    logic rx_pen;
    logic tx_pop;
    logic tx_load;
    logic tx_lvl;
    logic [7:0] tx_data;
    logic [`UFIR_CNT_W-1:0] tx_cnt;
    logic tx_empty;
    logic rx_push;
    logic rx_pop;
    logic rx_full;
    logic [`UFIR_CNT_W-1:0] rx_cnt;
    logic rx_raw;
    logic rx_seen;
    logic rx_lvl;
    logic rx_addr;
    logic [3:0] ls_set;
    logic [3:0] modem_chg;
    logic [3:0] fbits;
    logic [`UFIR_TO_W-1:0] to_limit;
    logic [`UFIR_IRQ_W-1:0] raw;
    logic [`UFIR_IRQ_W-1:0] ev_set;
    logic busy;

    // Fill threshold for a trigger select, never below one character
    function automatic logic [`UFIR_CNT_W-1:0] thr(input logic [1:0] sel);
        int t;
        case (sel)
            2'h0: t = 1;
            2'h1: t = DEPTH / 4;
            2'h2: t = DEPTH / 2;
            default: t = DEPTH - 2;
        endcase
        if (t < 1) begin
            t = 1;
        end
        thr = `UFIR_CNT_W'(t);
    endfunction

    // Data bits per character; infrared mode forces eight
    function automatic logic [3:0] dbits(input logic irm, input logic [1:0] wl);
        dbits = irm ? 4'h8 : 4'h5 + {2'h0, wl};
    endfunction

    // Parity over the valid data bits, even or odd
    function automatic logic par_of(input logic [7:0] d, input logic [3:0] n,
                                    input logic odd);
        par_of = (^(d & (8'hff >> (4'h8 - n)))) ^ odd;
    endfunction

    // Character queues
    ufir_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .push_i(tx_write_i),
        .data_i(transmit_holding_reg_i),
        .pop_i(tx_pop),
        .data_o(tx_data),
        .count_o(tx_cnt),
        .full_o(tx_full_o),
        .empty_o(tx_empty)
    );

    ufir_fifo #(.W(8), .DEPTH(DEPTH)) u_rx_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .push_i(rx_push),
        .data_i(s.rx_sh[7:0]),
        .pop_i(rx_pop),
        .data_o(receive_buffer_reg_o),
        .count_o(rx_cnt),
        .full_o(rx_full),
        .empty_o(rx_empty_o)
    );

    // Mode decode
    assign tick = (s.div_cnt == '0);
    assign ir = infrared_mode_enable_i;
    assign md_en = multidrop_control_reg_i[`UFIR_MD_EN];
    assign dir_en = multidrop_control_reg_i[`UFIR_MD_DIR];
    assign dir_sel = multidrop_control_reg_i[`UFIR_MD_SEL];
    assign acts = fifo_control_reg_i[`UFIR_FCR_ACTS] && !(dir_en && dir_sel);
    assign cts_stop = acts && s.sync2[`UFIR_SY_CTS];
    assign db = dbits(ir, line_control_reg_i[`UFIR_LCR_WLEN]);
    assign tx_pen = line_control_reg_i[`UFIR_LCR_PEN] && !ir;
    assign rx_pen = (line_control_reg_i[`UFIR_LCR_PEN] || md_en) && !ir;
    assign rx_pop = rx_read_i && !rx_empty_o;
    assign busy = (s.tx_st != ufir_pkg::TX_IDLE) || (s.rx_st != ufir_pkg::RX_IDLE) || !tx_empty;

    // Receive level: infrared maps any low in a bit, up to its middle sample, to a zero
    assign rx_raw = s.sync2[`UFIR_SY_RX];
    assign rx_seen = s.ir_seen || !rx_raw;
    assign rx_lvl = ir ? !rx_seen : rx_raw;
    assign rx_addr = md_en && s.rx_sh[8];

    // Character length for the timeout in sample ticks
    assign fbits = 4'h2 + db + {3'h0, rx_pen}
                   + {3'h0, line_control_reg_i[`UFIR_LCR_STOP2] && !ir};
    assign to_limit = `UFIR_TO_W'({fbits, 4'h0} * `UFIR_TO_CHARS);

    // Raw conditions: levels for queues, sticky for events
    assign raw[`UFIR_IRQ_RXAV] = rx_cnt >= thr(fifo_control_reg_i[`UFIR_FCR_RXTRG]);
    assign raw[`UFIR_IRQ_TXE] = FIFO_EN ? (tx_cnt <= thr(fifo_control_reg_i[`UFIR_FCR_TXTRG]))
                                        : tx_empty;
    assign raw[`UFIR_IRQ_LINE] = s.sticky[`UFIR_IRQ_LINE];
    assign raw[`UFIR_IRQ_MODEM] = s.sticky[`UFIR_IRQ_MODEM];
    assign raw[`UFIR_IRQ_TMO] = (s.to_cnt >= to_limit) && !rx_empty_o;
    assign raw[`UFIR_IRQ_BUSY] = s.sticky[`UFIR_IRQ_BUSY];

    // Status views and the single request line
    assign raw_irq_status_reg_o = raw;
    assign masked_status_reg_o = raw & s.mask;
    assign irq_mask_view_reg_o = s.mask;
    assign irq_o = |(raw & s.mask);
    assign line_status_o = s.line_flags;
    assign serial_out_pin_o = s.serial_out;
    assign request_send_out_n_o = s.rts_out;
    assign clear_send_out_n_o = s.cts_out;
    assign clear_send_oe_n_o = !(dir_en && dir_sel);

    // Transmit line level for the current frame position
    always_comb begin
        case (s.tx_st)
            ufir_pkg::TX_START: tx_lvl = 1'b0;
            ufir_pkg::TX_DATA: tx_lvl = s.tx_sh[0];
            ufir_pkg::TX_PAR: tx_lvl = s.tx_par;
            default: tx_lvl = 1'b1;
        endcase
    end

    // Next state of the whole channel
    always_comb begin
        next_s = s;
        tx_pop = 1'b0;
        tx_load = 1'b0;
        rx_push = 1'b0;
        ls_set = 4'h0;
        modem_chg = 4'h0;
        ev_set = '0;

        // Input synchronisers and sample tick
        next_s.sync1 = {carrier_det_n_i, ring_ind_n_i, data_set_ready_n_i,
                        clear_send_in_n_i, serial_in_pin_i};
        next_s.sync2 = s.sync1;
        next_s.div_cnt = tick ? sample_div_i : s.div_cnt - 1'b1;

        // Transmitter
        next_s.serial_out = ir ? (!tx_lvl && (s.tx_smp < `UFIR_IR_PULSE)) : tx_lvl;
        if (tick) begin
            case (s.tx_st)
                ufir_pkg::TX_IDLE: begin
                    tx_load = !tx_empty && !cts_stop;
                end
                ufir_pkg::TX_START: begin
                    next_s.tx_smp = s.tx_smp + 1'b1;
                    if (s.tx_smp == `UFIR_SMP_LAST) begin
                        next_s.tx_st = ufir_pkg::TX_DATA;
                    end
                end
                ufir_pkg::TX_DATA: begin
                    next_s.tx_smp = s.tx_smp + 1'b1;
                    if (s.tx_smp == `UFIR_SMP_LAST) begin
                        next_s.tx_sh = s.tx_sh >> 1;
                        next_s.tx_bit = s.tx_bit + 1'b1;
                        if (s.tx_bit == db - 4'h1) begin
                            next_s.tx_bit = 4'h0;
                            next_s.tx_st = tx_pen ? ufir_pkg::TX_PAR : ufir_pkg::TX_STOP;
                        end
                    end
                end
                ufir_pkg::TX_PAR: begin
                    next_s.tx_smp = s.tx_smp + 1'b1;
                    if (s.tx_smp == `UFIR_SMP_LAST) begin
                        next_s.tx_st = ufir_pkg::TX_STOP;
                    end
                end
                ufir_pkg::TX_STOP: begin
                    next_s.tx_smp = s.tx_smp + 1'b1;
                    // Decision point in the middle of the last stop bit
                    if (s.tx_smp == `UFIR_SMP_MID && (s.tx_bit != 4'h0 || ir
                        || !line_control_reg_i[`UFIR_LCR_STOP2])) begin
                        next_s.tx_hold = cts_stop;
                    end
                    if (s.tx_smp == `UFIR_SMP_LAST) begin
                        if (line_control_reg_i[`UFIR_LCR_STOP2] && !ir && s.tx_bit == 4'h0) begin
                            next_s.tx_bit = 4'h1;
                        end else if (!tx_empty && !s.tx_hold) begin
                            tx_load = 1'b1;
                        end else begin
                            next_s.tx_st = ufir_pkg::TX_IDLE;
                        end
                    end
                end
                default: begin
                    next_s.tx_st = ufir_pkg::TX_IDLE;
                end
            endcase
        end
        if (tx_load) begin
            tx_pop = 1'b1;
            next_s.tx_st = ufir_pkg::TX_START;
            next_s.tx_smp = '0;
            next_s.tx_bit = 4'h0;
            next_s.tx_hold = 1'b0;
            next_s.tx_sh = tx_data & (8'hff >> (4'h8 - db));
            next_s.tx_par = par_of(tx_data, db, line_control_reg_i[`UFIR_LCR_ODD]);
        end

        // Receiver
        if (tick) begin
            if (s.rx_st == ufir_pkg::RX_IDLE) begin
                if (!rx_raw) begin
                    next_s.rx_st = ufir_pkg::RX_START;
                    next_s.rx_smp = '0;
                    next_s.rx_bit = 4'h0;
                    next_s.rx_sh = '0;
                    next_s.ir_seen = 1'b1;
                end
            end else begin
                next_s.rx_smp = s.rx_smp + 1'b1;
                next_s.ir_seen = rx_seen;
                if (s.rx_smp == `UFIR_SMP_LAST) begin
                    next_s.ir_seen = 1'b0;
                end
                case (s.rx_st)
                    ufir_pkg::RX_START: begin
                        if (s.rx_smp == `UFIR_SMP_MID && rx_lvl) begin
                            next_s.rx_st = ufir_pkg::RX_IDLE;
                        end else if (s.rx_smp == `UFIR_SMP_LAST) begin
                            next_s.rx_st = ufir_pkg::RX_DATA;
                        end
                    end
                    ufir_pkg::RX_DATA: begin
                        if (s.rx_smp == `UFIR_SMP_MID) begin
                            next_s.rx_sh[s.rx_bit] = rx_lvl;
                        end
                        if (s.rx_smp == `UFIR_SMP_LAST) begin
                            next_s.rx_bit = s.rx_bit + 1'b1;
                            if (s.rx_bit == db - 4'h1) begin
                                next_s.rx_st = rx_pen ? ufir_pkg::RX_PAR : ufir_pkg::RX_STOP;
                            end
                        end
                    end
                    ufir_pkg::RX_PAR: begin
                        if (s.rx_smp == `UFIR_SMP_MID) begin
                            next_s.rx_sh[8] = rx_lvl;
                        end
                        if (s.rx_smp == `UFIR_SMP_LAST) begin
                            next_s.rx_st = ufir_pkg::RX_STOP;
                        end
                    end
                    ufir_pkg::RX_STOP: begin
                        // Finish in mid stop bit so the next start edge is caught
                        if (s.rx_smp == `UFIR_SMP_MID) begin
                            next_s.rx_st = ufir_pkg::RX_IDLE;
                            ls_set[`UFIR_LS_PAR] = md_en ? rx_addr
                                : rx_pen && (s.rx_sh[8] != par_of(s.rx_sh[7:0], db,
                                  line_control_reg_i[`UFIR_LCR_ODD]));
                            ls_set[`UFIR_LS_FRM] = !rx_lvl;
                            ls_set[`UFIR_LS_BRK] = !rx_lvl && (s.rx_sh == '0);
                            if (!(md_en && multidrop_control_reg_i[`UFIR_MD_BLOCK]
                                  && !rx_addr)) begin
                                ls_set[`UFIR_LS_OVR] = rx_full;
                                rx_push = !rx_full;
                            end
                        end
                    end
                    default: begin
                        next_s.rx_st = ufir_pkg::RX_IDLE;
                    end
                endcase
            end
        end

        // Receive timeout counter, restarted by any queue movement
        if (rx_push || rx_pop || rx_empty_o) begin
            next_s.to_cnt = '0;
        end else if (tick && s.to_cnt < to_limit) begin
            next_s.to_cnt = s.to_cnt + 1'b1;
        end

        // Flow control request line
        if (rx_cnt >= thr(fifo_control_reg_i[`UFIR_FCR_RXTRG])) begin
            next_s.rts_flag = 1'b1;
        end else if (rx_empty_o) begin
            next_s.rts_flag = 1'b0;
        end

        // Direction control level
        if (tx_write_i) begin
            next_s.dir_level = 1'b0;
        end else if (s.tx_st == ufir_pkg::TX_IDLE && tx_empty) begin
            next_s.dir_level = 1'b1;
        end
        next_s.rts_out = (dir_en && !dir_sel) ? s.dir_level
                         : (fifo_control_reg_i[`UFIR_FCR_ARTS] && s.rts_flag);
        next_s.cts_out = (dir_en && dir_sel) ? s.dir_level : 1'b1;

        // Event sources
        modem_chg = s.sync2[4:1] ^ s.modem_prev;
        next_s.modem_prev = s.sync2[4:1];
        if (acts) begin
            modem_chg[0] = 1'b0;
        end
        ev_set[`UFIR_IRQ_MODEM] = |modem_chg;
        ev_set[`UFIR_IRQ_LINE] = |ls_set;
        ev_set[`UFIR_IRQ_BUSY] = line_control_write_i && busy;

        // Sticky events: a set in the clear cycle wins
        next_s.sticky = (s.sticky & ~masked_status_clear_reg_i) | ev_set;
        if (masked_status_clear_reg_i[`UFIR_IRQ_LINE]) begin
            next_s.line_flags = ls_set;
        end else begin
            next_s.line_flags = s.line_flags | ls_set;
        end

        // Mask: enable writes win over disable writes on the same bit
        next_s.mask = (s.mask & ~irq_enable_clear_reg_i) | irq_enable_set_reg_i;
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end
endmodule

/* File: rtl/ufir_fifo.sv */
// Flip-flop FIFO used for the transmit and receive character queues.
// Assumes one clock; push when full and pop when empty are ignored.
`timescale 1ns/1ps
`include "ufir_regs.svh"
module ufir_fifo #(
    parameter int W = 8,
    parameter int DEPTH = `UFIR_FIFO_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic push_i,
    input wire logic [W-1:0] data_i,
    input wire logic pop_i,
    output logic [W-1:0] data_o,
    output logic [`UFIR_CNT_W-1:0] count_o,
    output logic full_o,
    output logic empty_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [`UFIR_CNT_W-1:0] cnt;
    } ufir_fifo_st_t;
    ufir_fifo_st_t s;
    ufir_fifo_st_t next_s;
    logic do_push;
    logic do_pop;

    // Pointer advance with wrap at the last slot
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign full_o = (s.cnt == `UFIR_CNT_W'(DEPTH));
    assign empty_o = (s.cnt == '0);
    assign count_o = s.cnt;
    assign data_o = s.mem[s.rp];
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;

    // Store, advance pointers and keep the fill count
    always_comb begin
        next_s = s;
        if (do_push) begin
            next_s.mem[s.wp] = data_i;
            next_s.wp = bump(s.wp);
        end
        if (do_pop) begin
            next_s.rp = bump(s.rp);
        end
        if (do_push && !do_pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

/* File: rtl/ufir_pkg.sv */
// Types shared by the UART channel: transmitter and receiver states.
// Assumes nothing of its surroundings.
package ufir_pkg;
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_PAR = 3'h2,
        TX_STOP = 3'h6
    } ufir_tx_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h3,
        RX_PAR = 3'h2,
        RX_STOP = 3'h6
    } ufir_rx_t;
endpackage

/* File: rtl/ufir_regs.svh */
// Field positions, reset values and timing counts of the UART channel.
// Included by the core and the FIFO; holds definitions only.
`ifndef UFIR_REGS_SVH
`define UFIR_REGS_SVH
`define UFIR_FIFO_DEPTH 16
`define UFIR_CNT_W 5
`define UFIR_DIV_W 16
`define UFIR_SMP_W 4
`define UFIR_SMP_LAST 4'hf
`define UFIR_SMP_MID 4'h7
`define UFIR_IR_PULSE 4'h3
`define UFIR_TO_CHARS 4
`define UFIR_TO_W 10
`define UFIR_IRQ_W 6
`define UFIR_IRQ_RXAV 0
`define UFIR_IRQ_TXE 1
`define UFIR_IRQ_LINE 2
`define UFIR_IRQ_MODEM 3
`define UFIR_IRQ_TMO 4
`define UFIR_IRQ_BUSY 5
`define UFIR_MASK_RST 6'h00
`define UFIR_FCR_RXTRG 1:0
`define UFIR_FCR_TXTRG 3:2
`define UFIR_FCR_ARTS 4
`define UFIR_FCR_ACTS 5
`define UFIR_LCR_WLEN 1:0
`define UFIR_LCR_STOP2 2
`define UFIR_LCR_PEN 3
`define UFIR_LCR_ODD 4
`define UFIR_MD_EN 0
`define UFIR_MD_BLOCK 1
`define UFIR_MD_DIR 2
`define UFIR_MD_SEL 3
`define UFIR_LS_OVR 0
`define UFIR_LS_PAR 1
`define UFIR_LS_FRM 2
`define UFIR_LS_BRK 3
`define UFIR_SY_RX 0
`define UFIR_SY_CTS 1
`define UFIR_SY_RST 5'h1f
`define UFIR_MODEM_RST 4'hf
`endif

/* File: test/ufir_checker.sv */
// Checker of the UART core: interrupt mask, request-to-send, infrared pulse.
// Assumes binding to ufir_core run with a sample divisor of zero.
`timescale 1ns/1ps
module ufir_checker (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] fifo_control_reg_i,
    input wire logic infrared_mode_enable_i,
    input wire logic [3:0] multidrop_control_reg_i,
    input wire logic rx_empty_o,
    input wire logic [5:0] irq_enable_set_reg_i,
    input wire logic [5:0] irq_enable_clear_reg_i,
    input wire logic [5:0] irq_mask_view_reg_o,
    input wire logic [5:0] raw_irq_status_reg_o,
    input wire logic [5:0] masked_status_reg_o,
    input wire logic irq_o,
    input wire logic serial_out_pin_o,
    input wire logic request_send_out_n_o
);
    logic auto_rts;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Auto request-to-send not overridden by direction control
    assign auto_rts = fifo_control_reg_i[4] && !multidrop_control_reg_i[2];
    a_mask_set: assert property (|irq_enable_set_reg_i |=>
        &(irq_mask_view_reg_o | ~$past(irq_enable_set_reg_i))) else $error("mask set");
    a_mask_clear: assert property (|irq_enable_clear_reg_i |=>
        !(|(irq_mask_view_reg_o & $past(irq_enable_clear_reg_i) & ~$past(irq_enable_set_reg_i))))
        else $error("mask clear");
    a_masked_view: assert property (
        masked_status_reg_o == (raw_irq_status_reg_o & irq_mask_view_reg_o)) else $error("view");
    a_irq_line: assert property (irq_o == |masked_status_reg_o) else $error("irq");
    a_rts_drop: assert property ((auto_rts && rx_empty_o)[*3] |-> !request_send_out_n_o)
        else $error("rts low");
    a_rts_raise: assert property (
        (auto_rts && fifo_control_reg_i[1:0] == 2'h0 && !rx_empty_o)[*3] |-> request_send_out_n_o)
        else $error("rts high");
    a_rts_manual: assert property (
        (!fifo_control_reg_i[4] && !multidrop_control_reg_i[2])[*2] |-> !request_send_out_n_o)
        else $error("rts idle");
    a_ir_pulse: assert property (infrared_mode_enable_i && $rose(serial_out_pin_o) |->
        serial_out_pin_o[*3] ##1 !serial_out_pin_o) else $error("pulse");
    cover property (auto_rts && $fell(request_send_out_n_o));
    cover property (infrared_mode_enable_i && $rose(serial_out_pin_o));
    cover property (irq_o);
endmodule

/* File: test/ufir_core_tb.sv */
// Bench of the UART core: masks, busy, flow control, multidrop, infrared.
// Assumes the fastest bit rate and the remote sender on the receive pin.
`timescale 1ns/1ps
module ufir_core_tb;
    logic ref_clk_i = 0, rst_n_i = 0, line_control_write_i = 0, infrared_mode_enable_i = 0;
    logic tx_write_i = 0, rx_read_i = 0, clear_send_in_n_i = 0, send = 0, lo, serial_in_pin_i;
    logic data_set_ready_n_i = 1, ring_ind_n_i = 1, carrier_det_n_i = 1, tx_full_o, rx_empty_o;
    logic irq_o, serial_out_pin_o, request_send_out_n_o, clear_send_out_n_o, clear_send_oe_n_o;
    logic [15:0] sample_div_i = 0;
    logic [5:0] fifo_control_reg_i = 0, irq_enable_set_reg_i = 0, irq_enable_clear_reg_i = 0;
    logic [5:0] masked_status_clear_reg_i = 0, irq_mask_view_reg_o, raw_irq_status_reg_o;
    logic [5:0] masked_status_reg_o;
    logic [4:0] line_control_reg_i = 5'h03;
    logic [3:0] multidrop_control_reg_i = 0, line_status_o;
    logic [7:0] transmit_holding_reg_i = 0, receive_buffer_reg_o;
    logic [8:0] chr = 0;
    int n_errors = 0, comparisons = 0, cycles = 0;
    ufir_core ufir_core_i (.*);
    ufir_remote ufir_remote_i (.ref_clk_i, .send_i(send), .chr_i(chr), .line_o(serial_in_pin_i));
    always #20 ref_clk_i = ~ref_clk_i;
    // Cycle ceiling against a hang
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rx(input logic [8:0] c);
        chr = c;
        send = 1;
        step(1);
        send = 0;
        step(200);
    endtask
    task automatic wr(input logic [7:0] b);
        transmit_holding_reg_i = b;
        tx_write_i = 1;
        step(1);
        tx_write_i = 0;
    endtask
    // Notes whether the serial output went low within k cycles
    task automatic watch(input int k);
        lo = 0;
        repeat (k) begin
            step(1);
            lo |= !serial_out_pin_o;
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        step(10);
        rst_n_i = 1;
        step(1);
        chk(raw_irq_status_reg_o, 16'h0002);
        irq_enable_set_reg_i = 6'h02;
        step(1);
        irq_enable_set_reg_i = 0;
        step(1);
        chk({irq_mask_view_reg_o, masked_status_reg_o, irq_o}, 16'h0105);
        irq_enable_clear_reg_i = 6'h02;
        step(1);
        irq_enable_clear_reg_i = 0;
        step(1);
        chk({irq_mask_view_reg_o, irq_o}, 16'h0000);
        wr(8'h5a);
        step(40);
        line_control_write_i = 1;
        step(1);
        line_control_write_i = 0;
        step(1);
        chk(raw_irq_status_reg_o[5], 16'h0001);
        masked_status_clear_reg_i = 6'h20;
        step(1);
        masked_status_clear_reg_i = 0;
        step(200);
        chk(raw_irq_status_reg_o[5], 16'h0000);
        fifo_control_reg_i = 6'h10;
        rx(9'h135);
        chk({request_send_out_n_o, receive_buffer_reg_o}, 16'h0135);
        step(700);
        chk(raw_irq_status_reg_o[4], 16'h0001);
        rx_read_i = 1;
        step(1);
        rx_read_i = 0;
        step(2);
        chk({rx_empty_o, request_send_out_n_o}, 16'h0002);
        multidrop_control_reg_i = 4'h3;
        line_control_reg_i = 5'h0b;
        rx(9'h011);
        chk(rx_empty_o, 16'h0001);
        rx(9'h17a);
        chk({line_status_o[1], receive_buffer_reg_o}, 16'h017a);
        multidrop_control_reg_i = 0;
        infrared_mode_enable_i = 1;
        wr(8'h00);
        step(200);
        infrared_mode_enable_i = 0;
        fifo_control_reg_i = 6'h20;
        masked_status_clear_reg_i = 6'h08;
        step(1);
        masked_status_clear_reg_i = 0;
        clear_send_in_n_i = 1;
        step(4);
        chk(raw_irq_status_reg_o[3], 16'h0000);
        wr(8'h0f);
        watch(400);
        chk(lo, 16'h0000);
        clear_send_in_n_i = 0;
        watch(40);
        chk(lo, 16'h0001);
        step(200);
        multidrop_control_reg_i = 4'h4;
        step(2);
        chk(request_send_out_n_o, 16'h0001);
        wr(8'h55);
        step(1);
        chk(request_send_out_n_o, 16'h0000);
        step(200);
        chk(request_send_out_n_o, 16'h0001);
        multidrop_control_reg_i = 4'hc;
        step(2);
        chk({clear_send_oe_n_o, clear_send_out_n_o, request_send_out_n_o}, 16'h0002);
        summarize();
    end
endmodule
bind ufir_core ufir_checker ufir_checker_i (.*);

/* File: test/ufir_remote.sv */
// Remote sender on the core's receive pin; idle line high.
// Assumes sixteen clocks to a bit; a ninth bit of 1 doubles as stop.
`timescale 1ns/1ps
module ufir_remote (
    input wire logic ref_clk_i,
    input wire logic send_i,
    input wire logic [8:0] chr_i,
    output logic line_o
);
    logic [10:0] bits = 11'h7ff;
    logic [7:0] n = 8'h00;
    assign line_o = bits[0];
    // Start, data least significant first, ninth bit, stop
    always @(posedge ref_clk_i) begin
        if (send_i && n == 8'h00) begin
            bits <= {1'h1, chr_i, 1'h0};
            n <= 8'hb0;
        end else if (n != 8'h00) begin
            n <= n - 8'h01;
            if (n[3:0] == 4'h1)
                bits <= {1'h1, bits[10:1]};
        end
    end
endmodule
